// >>> design/rfc_flow_ctrl.sv
`timescale 1ns/100ps
// Automatic receive flow controller
module rfc_flow_ctrl
    import rfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic tx_enabled,
    input wire logic full_duplex,
    input wire logic speed_10,
    input wire logic [RFC_LEVEL_W-1:0] rx_fifo_level,
    input wire rfc_rxfrm_t rx_frame,
    output rfc_mac_t mac_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        rfc_jam_st_t jst;          // Jam sequencer
        logic [RFC_CNT_W-1:0] cnt; // Jam time left
        logic episode;             // Pause sent, zero pause owed
        rfc_mac_t mac;             // Outputs to MAC
    } rfc_st_t;

    rfc_st_t st_q;
    rfc_st_t st_d;

    logic [31:0] cfg;
    logic [31:0] stat;
    logic [RFC_CNT_W-1:0] dur_cycles;
    logic [7:0] hi_thr;
    logic [7:0] lo_thr;
    logic [7:0] fill_units;  // FIFO fill in 64-byte units
    logic at_high;
    logic below_low;
    logic qual_hit;
    logic enabled;

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave
    rfc_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .stat(stat),
        .rdata_q(reg_rdata),
        .cfg_q(cfg)
    );

    // Duration lookup
    rfc_dur_lut u_lut (
        .clk(clk),
        .rst_n(rst_n),
        .code(cfg[RFC_DUR_LSB +: 4]),  // see [RQ8]
        .speed_10(speed_10),
        .cycles_q(dur_cycles)
    );

    // Status word: state of the controller
    assign stat = {28'h0000000, st_q.mac.jam, st_q.episode, at_high, below_low};

    ////////////////////////////////////////////////////////////////////////////////
    // Threshold compare
    always_comb begin
        hi_thr = cfg[RFC_HI_LSB +: 8];  // see [RQ2]
        lo_thr = cfg[RFC_LO_LSB +: 8];  // see [RQ5]
        fill_units = 8'(rx_fifo_level >> RFC_UNIT_SHIFT);
        at_high = fill_units >= hi_thr;  // see [RQ2]
        below_low = fill_units < lo_thr;  // see [RQ5]
        // Any-frame overrides the other qualifiers
        if (cfg[RFC_Q_ANY]) begin  // see [RQ12]
            qual_hit = 1'b1;
        end else begin
            qual_hit = (cfg[RFC_Q_MCAST] && rx_frame.mcast)      // see [RQ9]
                    || (cfg[RFC_Q_BCAST] && rx_frame.bcast)      // see [RQ10]
                    || (cfg[RFC_Q_ADDR] && rx_frame.own_addr);   // see [RQ11]
        end
        enabled = |cfg[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.mac.pause_req = 1'b0;
        st_d.mac.zero_time = 1'b0;
        if (!tx_enabled) begin
            // Transmitter off: nothing goes out
            st_d.jst = RFC_IDLE;  // see [RQ1]
            st_d.cnt = '0;
            st_d.mac.jam = 1'b0;  // see [RQ1]
        end else if (full_duplex) begin
            st_d.jst = RFC_IDLE;
            st_d.mac.jam = 1'b0;  // see [RQ8]
            if (cfg[RFC_Q_ANY] && at_high && !st_q.episode) begin
                // Single pause per episode, requested at once
                st_d.mac.pause_req = 1'b1;  // see [RQ3] see [RQ13]
                st_d.episode = 1'b1;  // see [RQ15]
            end else if (st_q.episode && enabled && below_low) begin
                st_d.mac.pause_req = 1'b1;  // see [RQ6]
                st_d.mac.zero_time = 1'b1;  // see [RQ5]
                st_d.episode = 1'b0;  // see [RQ15]
            end
        end else begin
            // Half duplex backpressure
            case (st_q.jst)
                RFC_IDLE: begin
                    if (rx_frame.valid && at_high && qual_hit) begin  // see [RQ4]
                        st_d.jst = RFC_JAM;
                        st_d.cnt = dur_cycles;
                        st_d.mac.jam = 1'b1;
                    end
                end
                RFC_JAM: begin
                    if (st_q.cnt <= RFC_CNT_W'(1)) begin  // see [RQ8]
                        st_d.jst = RFC_IDLE;
                        st_d.cnt = '0;
                        st_d.mac.jam = 1'b0;
                    end else begin
                        st_d.cnt = st_q.cnt - RFC_CNT_W'(1);
                    end
                end
                default: begin
                    st_d.jst = RFC_IDLE;
                    st_d.mac.jam = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{jst: RFC_IDLE, cnt: '0, episode: 1'b0, mac: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign mac_q = st_q.mac;

endmodule : rfc_flow_ctrl

// >>> design/rfc_pkg.sv
//
// Function
// [RQ1] No pause or jam while transmitter disabled
// [RQ2] High threshold bits 23:16, 64-byte units
// [RQ3] Full duplex: one pause frame at high
// [RQ4] Half duplex: jam qualifying frames for duration
// [RQ5] Low threshold 15:8; zero pause below it
// [RQ6] Zero pause only after high pause sent
// [RQ7] Software keeps low below high threshold
// [RQ8] Duration field 7:4, unused in full duplex
// [RQ9] Multicast qualifier bit 3 triggers jam
// [RQ10] Broadcast qualifier bit 2 triggers jam
// [RQ11] Own-address qualifier bit 1 triggers jam
// [RQ12] Any-frame bit 0 overrides, enables full duplex
// [RQ13] Full duplex any-frame: request pause immediately
// [RQ14] Duration code table, 10 Mb/s adds 2.2us
// [RQ15] Episode flag limits zero pause to once
package rfc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] RFC_CFG_OFFSET = 8'hac;
    localparam logic [31:0] RFC_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] RFC_CFG_MASK = 32'h00ff_ffff;  // Bits 31:24 reserved
    // Status register of own choosing
    localparam logic [7:0] RFC_STAT_OFFSET = 8'hb4;

    // Field positions
    localparam int RFC_HI_LSB = 16;
    localparam int RFC_LO_LSB = 8;
    localparam int RFC_DUR_LSB = 4;
    localparam int RFC_Q_ANY = 0;
    localparam int RFC_Q_ADDR = 1;
    localparam int RFC_Q_BCAST = 2;
    localparam int RFC_Q_MCAST = 3;

    // Threshold unit: 64 bytes -> shift of 6
    localparam int RFC_UNIT_SHIFT = 6;
    localparam int RFC_LEVEL_W = 14;  // FIFO fill in bytes

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int RFC_CLK_MHZ = 200;
    localparam int RFC_US_TICKS = RFC_CLK_MHZ;  // Cycles per microsecond
    localparam int RFC_EXTRA_NS = 2200;  // 10 Mb/s extension in ns
    localparam int RFC_CLK_NS = 5;
    localparam int RFC_EXTRA_CYC = RFC_EXTRA_NS / RFC_CLK_NS;
    localparam int RFC_CNT_W = 18;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic valid;      // One-cycle frame start pulse
        logic mcast;
        logic bcast;
        logic own_addr;
    } rfc_rxfrm_t;

    typedef struct packed {
        logic pause_req;  // One-cycle request
        logic zero_time;  // 1: pause time zero, 0: use pause_time_value
        logic jam;        // Backpressure level
    } rfc_mac_t;

    typedef enum logic [1:0] {
        RFC_IDLE = 2'b00,
        RFC_JAM = 2'b01
    } rfc_jam_st_t;

endpackage : rfc_pkg

// >>> design/rfc_dur_lut.sv
`timescale 1ns/100ps
// Backpressure duration code to cycle count, registered
module rfc_dur_lut
    import rfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] code,
    input wire logic speed_10,
    output logic [RFC_CNT_W-1:0] cycles_q
);
    typedef struct packed {
        logic [RFC_CNT_W-1:0] cycles;
    } rfc_lut_st_t;

    rfc_lut_st_t st_q;
    rfc_lut_st_t st_d;
    logic [9:0] us;  // Duration in microseconds

    // Code table at 100 Mb/s
    always_comb begin  // see [RQ14]
        case (code)
            4'h0: us = 10'h005;
            4'h1: us = 10'h00a;
            4'h2: us = 10'h00f;
            4'h3: us = 10'h019;
            default: us = 10'((int'(code) - 3) * 50);
        endcase
        st_d.cycles = RFC_CNT_W'(int'(us) * RFC_US_TICKS
                      + (speed_10 ? RFC_EXTRA_CYC : 0));
    end

    // Register the count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cycles_q = st_q.cycles;

endmodule : rfc_dur_lut

// >>> design/rfc_regs.sv
`timescale 1ns/100ps
// Configuration register slave
module rfc_regs
    import rfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] stat,
    output logic [31:0] rdata_q,
    output logic [31:0] cfg_q
);
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
    } rfc_reg_st_t;

    rfc_reg_st_t st_q;
    rfc_reg_st_t st_d;

    // Decode writes and reads
    always_comb begin
        st_d = st_q;
        st_d.rdata = 32'h0000_0000;  // Unmapped and idle read zero
        if (wr && addr == RFC_CFG_OFFSET) begin
            st_d.cfg = wdata & RFC_CFG_MASK;  // Reserved bits stay zero
        end
        if (rd) begin
            case (addr)
                RFC_CFG_OFFSET: st_d.rdata = st_q.cfg;
                RFC_STAT_OFFSET: st_d.rdata = stat;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{cfg: RFC_CFG_RESET, rdata: 32'h0000_0000};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_q = st_q.rdata;
    assign cfg_q = st_q.cfg;

endmodule : rfc_regs

// >>> test/rfc_flow_ctrl_properties.sv
`timescale 1ns/100ps
// Port checker for the flow controller
module rfc_flow_ctrl_properties
    import rfc_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    input logic tx_enabled,
    input logic full_duplex,
    input logic [RFC_LEVEL_W-1:0] rx_fifo_level,
    input rfc_rxfrm_t rx_frame,
    input rfc_mac_t mac_q
);
    logic [31:0] cfg_q;  // Shadow config
    logic ep_q;  // Zero pause owed
    logic hi;  // Fill at high mark
    logic lo;  // Fill under low mark
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign hi = rx_fifo_level[13:6] >= cfg_q[23:16];
    assign lo = rx_fifo_level[13:6] < cfg_q[15:8];
    ////////////////////
    // Shadow state from port traffic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
            ep_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == RFC_CFG_OFFSET) cfg_q <= reg_wdata & RFC_CFG_MASK;
            if (mac_q.pause_req) ep_q <= !mac_q.zero_time;
        end
    end
    ////////////////////
    a_tx_off_quiet: assert property (
        !tx_enabled |=> !mac_q.pause_req && !mac_q.jam)
        else $error("pause or jam, tx off");
    a_pause_pulse: assert property (
        mac_q.pause_req |=> !mac_q.pause_req)
        else $error("pause not a pulse");
    a_pause_cause: assert property (
        mac_q.pause_req && !mac_q.zero_time |-> $past(hi) && $past(full_duplex))
        else $error("pause without high fill");
    a_pause_once: assert property (
        mac_q.pause_req && !mac_q.zero_time |-> !ep_q)
        else $error("second pause in episode");
    a_zero_after: assert property (
        mac_q.zero_time |-> mac_q.pause_req && ep_q && $past(lo))
        else $error("zero pause out of place");
    a_jam_cause: assert property (
        $rose(mac_q.jam) |-> $past(rx_frame.valid) && $past(hi))
        else $error("jam without frame");
    a_jam_holds: assert property (
        $rose(mac_q.jam) && tx_enabled |=> mac_q.jam)
        else $error("jam too short");
    a_cfg_read: assert property (
        reg_rd && reg_addr == RFC_CFG_OFFSET |=> reg_rdata == cfg_q)
        else $error("config readback");
endmodule : rfc_flow_ctrl_properties

bind rfc_flow_ctrl rfc_flow_ctrl_properties chk (.*);

// >>> test/rfc_mac_model.sv
`timescale 1ns/100ps
// MAC transmitter, receive filter and FIFO stand-in
module rfc_mac_model
    import rfc_pkg::*;
(
    input logic clk,
    input rfc_mac_t mac_q,
    output logic tx_enabled,
    output logic full_duplex,
    output logic speed_10,
    output logic [RFC_LEVEL_W-1:0] rx_fifo_level,
    output rfc_rxfrm_t rx_frame
);
    int n_pause = 0;  // Timed pauses queued
    int n_zero = 0;  // Zero pauses queued
    int run = 0;  // Current jam burst
    int jam_len = 0;  // Last jam burst
    initial begin
        {tx_enabled, full_duplex, speed_10} = 3'b100;
        rx_fifo_level = '0;
        rx_frame = '0;
    end
    // Count timed and zero pauses, time jams
    always @(posedge clk) begin
        if (mac_q.pause_req && mac_q.zero_time) n_zero++;
        if (mac_q.pause_req && !mac_q.zero_time) n_pause++;
        run = mac_q.jam ? run + 1 : 0;
        if (mac_q.jam) jam_len = run;
    end
    // One frame start, then flags invert
    task automatic frame(input logic [2:0] f);
        @(posedge clk);
        rx_frame <= {1'b1, f};
        @(posedge clk);
        rx_frame <= {1'b0, ~f};
    endtask : frame
endmodule : rfc_mac_model

// >>> test/test_rx_fifo_flow_control.sv
`timescale 1ns/100ps
// Bench for the flow controller
module test_rx_fifo_flow_control
    import rfc_pkg::*;
;
    typedef struct {
        logic [31:0] cfg;
        logic fd;
        logic s10;
        logic [2:0] fl;
        logic [31:0] len;
    } rfc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tx_enabled, full_duplex, speed_10;
    logic [RFC_LEVEL_W-1:0] rx_fifo_level;
    rfc_rxfrm_t rx_frame;
    rfc_mac_t mac_q;
    int error_cnt = 0;
    int n_checks = 0;
    // Config, duplex, 10 Mb/s, flags, jam cycles; low under high
    rfc_row_t rows[6] = '{
        '{32'h0002_0108, 1'b0, 1'b0, 3'b100, 1000},
        '{32'h0002_0104, 1'b0, 1'b1, 3'b010, 1440},
        '{32'h0002_0112, 1'b0, 1'b0, 3'b001, 2000},
        '{32'h0002_0101, 1'b0, 1'b0, 3'b000, 1000},
        '{32'h0002_0108, 1'b0, 1'b0, 3'b010, 0},
        '{32'h0002_0108, 1'b1, 1'b0, 3'b100, 0}};
    always #2.5 clk = ~clk;
    rfc_flow_ctrl dut (.*);
    rfc_mac_model mac (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic lvl(input logic [13:0] v, input int n);
        mac.rx_fifo_level <= v;
        cyc(n);
    endtask : lvl
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Watchdog
    initial begin
        #200us;
        error_cnt++;
        close_out();
    end
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        rd(RFC_CFG_OFFSET, 32'h0);
        rd(RFC_STAT_OFFSET, 32'h0000_0002);
        wr(RFC_CFG_OFFSET, 32'hffff_ffff);
        rd(RFC_CFG_OFFSET, 32'h00ff_ffff);
        rd(8'h10, 32'h0);
        mac.rx_fifo_level <= 14'd200;
        foreach (rows[i]) begin
            wr(RFC_CFG_OFFSET, rows[i].cfg);
            {mac.full_duplex, mac.speed_10} <= {rows[i].fd, rows[i].s10};
            mac.jam_len = 0;
            mac.frame(rows[i].fl);
            cyc(2600);
            check(mac.jam_len, rows[i].len);
        end
        lvl(14'd0, 20);
        check(mac.n_zero, 0);
        wr(RFC_CFG_OFFSET, 32'h0002_0101);
        lvl(14'd128, 50);
        check(mac.n_pause, 1);
        lvl(14'd64, 20);
        check(mac.n_zero, 0);
        lvl(14'd63, 20);
        check(mac.n_zero, 1);
        mac.tx_enabled <= 1'b0;
        lvl(14'd200, 20);
        check(mac.n_pause, 1);
        mac.full_duplex <= 1'b0;
        lvl(14'd0, 2);
        mac.tx_enabled <= 1'b1;
        lvl(14'd200, 0);
        mac.frame(3'b000);
        cyc(100);
        mac.tx_enabled <= 1'b0;
        cyc(20);
        check(mac.jam_len, 101);
        // Mid-run reset clears outputs and config
        mac.tx_enabled <= 1'b1;
        mac.frame(3'b000);
        cyc(5);
        rst_n <= 1'b0;
        cyc(2);
        check(32'(mac_q), 32'h0);
        rst_n <= 1'b1;
        rd(RFC_CFG_OFFSET, 32'h0);
        close_out();
    end
endmodule : test_rx_fifo_flow_control
